//--- rtl/sxa_alu.v
/*
 * Datapath slice executing five operations against the accumulator and the
 * 128-byte data register file, with carry, nibble carry and zero flags.
 * Assumes the decode holds op_valid for one cycle per operation and waits
 * for op_done before issuing the next; the register file read takes one
 * cycle, so register operations finish on the second edge.
 */
`include "sxa_map.vh"

module sxa_alu (
  input  wire       core_clk,
  input  wire       resetn,
  input  wire       op_valid,
  input  wire [2:0] op_sel,
  input  wire [7:0] literal,
  input  wire [6:0] file_addr,
  input  wire       target,
  input  wire       host_wr_en,
  input  wire [6:0] host_addr,
  input  wire [7:0] host_wr_data,
  output wire       op_ready,
  output reg        op_done,
  output reg  [7:0] acc,
  output reg  [7:0] result,
  output reg        carry_flag,
  output reg        nibble_carry_flag,
  output reg        zero_flag,
  output wire [7:0] host_rd_data
);

  // ****************************************************
  // Local state
  // ****************************************************
  localparam ST_IDLE = 1'b0;
  localparam ST_FILE = 1'b1;

  reg        state;
  reg  [2:0] op_hold;
  reg  [6:0] addr_hold;
  reg        target_hold;
  reg  [7:0] next_acc;
  reg  [7:0] next_result;
  reg  [2:0] next_flags;
  reg  [2:0] flag_mask;
  reg        file_wr;
  wire [7:0] file_q;

  // Subtract a from b, returns {carry, nibble carry, difference}
  function [9:0] sub_flags;
    input [7:0] b;
    input [7:0] a;
    reg   [8:0] full;
    reg   [4:0] low;
    begin
      full = {1'b0, b} - {1'b0, a};
      low = {1'b0, b[3:0]} - {1'b0, a[3:0]};
      sub_flags = {~full[8], ~low[4], full[7:0]};
    end
  endfunction

  // ****************************************************
  // Operation decode
  // ****************************************************
  // Literal operations need no register file read
  function is_literal_op;
    input [2:0] op;
    begin
      is_literal_op = (op == `SXA_OP_LITERAL_MINUS_ACC) ||
                      (op == `SXA_OP_LITERAL_PARITY_MIX);
    end
  endfunction

  // Register operations wait one cycle for the file read
  function is_file_op;
    input [2:0] op;
    begin
      is_file_op = (op == `SXA_OP_FILE_MINUS_ACC) ||
                   (op == `SXA_OP_FILE_EXCLUSIVE_OR) ||
                   (op == `SXA_OP_NIBBLE_EXCHANGE);
    end
  endfunction

  // ****************************************************
  // Operation evaluation
  // ****************************************************
  // Operand comes from the literal or the register file read data
  always @* begin : eval
    reg [9:0] d;
    reg [7:0] src;
    d = 10'h000;
    src = (state == ST_IDLE) ? literal : file_q;
    next_result = `SXA_RESULT_RESET;
    flag_mask = 3'h0;
    next_flags = 3'h0;
    case ((state == ST_IDLE) ? op_sel : op_hold)
      `SXA_OP_LITERAL_MINUS_ACC, `SXA_OP_FILE_MINUS_ACC: begin
        d = sub_flags(src, acc);
        next_result = d[7:0];
        flag_mask = 3'h7;
        next_flags[`SXA_FLAG_CARRY] = d[9];
        next_flags[`SXA_FLAG_NIBBLE_CARRY] = d[8];
        next_flags[`SXA_FLAG_ZERO] = (d[7:0] == 8'h00);
      end
      `SXA_OP_LITERAL_PARITY_MIX, `SXA_OP_FILE_EXCLUSIVE_OR: begin
        next_result = acc ^ src;
        flag_mask = 3'h4;
        next_flags[`SXA_FLAG_ZERO] = (next_result == 8'h00);
      end
      `SXA_OP_NIBBLE_EXCHANGE: begin
        next_result = {src[3:0], src[7:4]};
      end
      default: begin
        next_result = `SXA_RESULT_RESET;
      end
    endcase
  end

  // Literal ops finish in idle; register ops finish in ST_FILE
  wire finish = (state == ST_IDLE) ?
                (op_valid && is_literal_op(op_sel)) :
                1'b1;
  wire to_acc = (state == ST_IDLE) || !target_hold;

  // Destination selection
  always @* begin
    next_acc = (finish && to_acc) ? next_result : acc;
    file_wr = (state == ST_FILE) && target_hold;
  end

  assign op_ready = (state == ST_IDLE);

  // ****************************************************
  // Sequencer
  // ****************************************************
  // Register operations capture operands and wait for the read
  wire start_file = op_ready && op_valid && is_file_op(op_sel);

  // Two-state control: idle, or second cycle of a register operation
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_file) begin
            state <= ST_FILE;
          end
        end
        ST_FILE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Operands held for the second cycle; the decode may move on
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      op_hold <= 3'h0;
      addr_hold <= 7'h00;
      target_hold <= 1'b0;
    end else if (start_file) begin
      op_hold <= op_sel;
      addr_hold <= file_addr;
      target_hold <= target;
    end
  end

  // ****************************************************
  // Accumulator, result and flags
  // ****************************************************
  // Accumulator keeps its value unless it is the destination
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      acc <= `SXA_ACC_RESET;
    end else begin
      acc <= next_acc;
    end
  end

  // Retirement pulse and last result
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      op_done <= 1'b0;
      result <= `SXA_RESULT_RESET;
    end else begin
      op_done <= finish;
      if (finish) begin
        result <= next_result;
      end
    end
  end

  // A flag moves only when the finishing operation affects it
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      {zero_flag, nibble_carry_flag, carry_flag} <= `SXA_FLAGS_RESET;
    end else if (finish) begin
      if (flag_mask[`SXA_FLAG_CARRY]) begin
        carry_flag <= next_flags[`SXA_FLAG_CARRY];
      end
      if (flag_mask[`SXA_FLAG_NIBBLE_CARRY]) begin
        nibble_carry_flag <= next_flags[`SXA_FLAG_NIBBLE_CARRY];
      end
      if (flag_mask[`SXA_FLAG_ZERO]) begin
        zero_flag <= next_flags[`SXA_FLAG_ZERO];
      end
    end
  end

  // ****************************************************
  // Register file
  // ****************************************************
  // Host port writes only while the slice is idle; reads use host_addr unless an idle request is presented
  wire       ram_wr = file_wr || (host_wr_en && state == ST_IDLE);
  wire [6:0] ram_wa = file_wr ? addr_hold : host_addr;
  wire [7:0] ram_wd = file_wr ? next_result : host_wr_data;
  wire [6:0] ram_ra = (state == ST_IDLE && op_valid) ? file_addr : host_addr;

  sxa_file_ram u_ram (
    .core_clk (core_clk),
    .wr_en    (ram_wr),
    .wr_addr  (ram_wa),
    .wr_data  (ram_wd),
    .rd_addr  (ram_ra),
    .rd_data  (file_q)
  );

  assign host_rd_data = file_q;

endmodule

//--- rtl/sxa_file_ram.v
/*
 * Data register file of 128 bytes with registered read data.
 * Assumes one write port and one read port on the core clock.
 */
module sxa_file_ram (
  input  wire       core_clk,
  input  wire       wr_en,
  input  wire [6:0] wr_addr,
  input  wire [7:0] wr_data,
  input  wire [6:0] rd_addr,
  output reg  [7:0] rd_data
);

  reg [7:0] mem [0:127];

  // Write port and registered read port
  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

//--- rtl/sxa_map.vh
/*
 * Constants for the subtract, exclusive-or and nibble-exchange datapath
 * slice of an 8-bit core: operation codes, flag positions, reset values.
 * Assumes the instruction decode presents one operation per request.
 */
// Summary of operation
// - Literal minus accumulator to accumulator; carry, nibble, zero
// - Literal exclusive-or accumulator, only zero flag
// - Register minus accumulator, target bit picks destination
// - Register exclusive-or accumulator, target bit, zero only
// - Exchange register nibbles, target bit, no flags
`ifndef SXA_MAP_VH
`define SXA_MAP_VH

// Operation codes on op_sel
`define SXA_OP_LITERAL_MINUS_ACC    3'h0
`define SXA_OP_LITERAL_PARITY_MIX   3'h1
`define SXA_OP_FILE_MINUS_ACC       3'h2
`define SXA_OP_FILE_EXCLUSIVE_OR    3'h3
`define SXA_OP_NIBBLE_EXCHANGE      3'h4

// Flag positions in the three-bit flag vector
`define SXA_FLAG_CARRY              0
`define SXA_FLAG_NIBBLE_CARRY       1
`define SXA_FLAG_ZERO               2

// Reset values
`define SXA_ACC_RESET               8'h00
`define SXA_FLAGS_RESET             3'h0
`define SXA_RESULT_RESET            8'h00

// Register address width (0 to 127)
`define SXA_ADDR_W                  7

`endif

//--- test/sxa_alu_props.sv
/* Checker for the datapath slice: timing, values and flag updates.
   Assumes it is bound to sxa_alu and sees only its ports. */
module sxa_alu_props (
  input logic       core_clk,
  input logic       resetn,
  input logic       op_valid,
  input logic [2:0] op_sel,
  input logic [7:0] literal,
  input logic       target,
  input logic       op_ready,
  input logic       op_done,
  input logic [7:0] acc,
  input logic [7:0] result,
  input logic       carry_flag,
  input logic       nibble_carry_flag,
  input logic       zero_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic [2:0] flg;
  logic       take;
  // Taken request and packed flags
  assign take = op_valid && op_ready;
  assign flg  = {zero_flag, nibble_carry_flag, carry_flag};
  a_lit_sub_value: assert property (take && op_sel == 3'h0 |=>
    op_done && acc == $past(literal) - $past(acc)) else $error("lit sub");
  a_sub_borrow_flags: assert property (take && op_sel == 3'h0 |=>
    carry_flag == ($past(literal) >= $past(acc)) && zero_flag == (acc == 0)
    && nibble_carry_flag == ($past(literal[3:0]) >= $past(acc[3:0])))
    else $error("sub flags");
  a_lit_xor_value: assert property (take && op_sel == 3'h1 |=>
    acc == ($past(literal) ^ $past(acc)) && zero_flag == (acc == 0)
    && $stable(carry_flag) && $stable(nibble_carry_flag)) else $error("xor");
  a_file_sub_timing: assert property (take && op_sel == 3'h2 |=>
    !op_ready ##1 op_done && zero_flag == (result == 0)
    && (acc == result || $past(target, 2))) else $error("file sub");
  a_file_xor_dest: assert property (take && op_sel == 3'h3 |-> ##2
    op_done && zero_flag == (result == 0) && carry_flag == $past(carry_flag, 2)
    && ($past(target, 2) ? acc == $past(acc, 2) : acc == result))
    else $error("file xor");
  a_swap_flags_kept: assert property (take && op_sel == 3'h4 |-> ##2
    op_done && flg == $past(flg, 2)) else $error("swap flags");
endmodule

//--- test/sxa_alu_test.sv
/* Self-checking bench for sxa_alu: literal, register and swap operations.
   Assumes the header sxa_map.vh is on the include path. */
`include "sxa_map.vh"
module sxa_alu_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic       core_clk = 0, resetn = 0, op_valid = 0, target = 0;
  logic       host_wr_en = 0, op_ready, op_done;
  logic       carry_flag, nibble_carry_flag, zero_flag;
  logic [2:0] op_sel = 3'h0;
  logic [6:0] file_addr = 7'h00, host_addr = 7'h00;
  logic [7:0] literal = 8'h00, host_wr_data = 8'h00;
  logic [7:0] acc, result, host_rd_data;
  int         error_cnt = 0, total_checks = 0, cycles = 0;
  sxa_alu dut (.core_clk, .resetn, .op_valid, .op_sel, .literal, .file_addr,
    .target, .host_wr_en, .host_addr, .host_wr_data, .op_ready, .op_done,
    .acc, .result, .carry_flag, .nibble_carry_flag, .zero_flag,
    .host_rd_data);
  // Clock and hang guard
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task wr_file(input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk);
    host_wr_en <= 1'b1;
    host_addr <= a;
    host_wr_data <= d;
    @(posedge core_clk);
    host_wr_en <= 1'b0;
  endtask
  task chk_file(input logic [6:0] a, input logic [7:0] e);
    @(posedge core_clk);
    host_addr <= a;
    repeat (2) @(posedge core_clk);
    #1 check(host_rd_data, e);
  endtask
  // One request, wait for retirement, then compare outputs
  task run(input logic [2:0] s, input logic [7:0] k, input logic [6:0] a,
    input logic t, input logic [7:0] ea, er, input logic [2:0] ef);
    int n;
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_sel <= s;
    literal <= k;
    file_addr <= a;
    target <= t;
    @(posedge core_clk);
    op_valid <= 1'b0;
    #1 n = 0;
    check({7'h00, op_ready}, {7'h00, s < `SXA_OP_FILE_MINUS_ACC});
    while (op_done !== 1'b1 && n < 4) begin
      @(posedge core_clk);
      #1 n++;
    end
    check({7'h00, op_done}, 8'h01);
    check(acc, ea);
    check(result, er);
    check({5'h00, zero_flag, nibble_carry_flag, carry_flag}, {5'h00, ef});
  endtask
  task lit_ops;
    run(`SXA_OP_LITERAL_MINUS_ACC, 8'h05, 0, 0, 8'h05, 8'h05, 3'h3);
    run(`SXA_OP_LITERAL_PARITY_MIX, 8'h05, 0, 0, 8'h00, 8'h00, 3'h7);
    run(`SXA_OP_LITERAL_MINUS_ACC, 8'h10, 0, 0, 8'h10, 8'h10, 3'h3);
    run(`SXA_OP_LITERAL_MINUS_ACC, 8'h0f, 0, 0, 8'hff, 8'hff, 3'h2);
  endtask
  task file_ops;
    wr_file(7'h7f, 8'h3c);
    wr_file(7'h00, 8'h03);
    run(`SXA_OP_FILE_MINUS_ACC, 0, 7'h7f, 1, 8'hff, 8'h3d, 3'h0);
    chk_file(7'h7f, 8'h3d);
    run(`SXA_OP_FILE_MINUS_ACC, 0, 7'h7f, 0, 8'h3e, 8'h3e, 3'h0);
    run(`SXA_OP_FILE_EXCLUSIVE_OR, 0, 7'h7f, 0, 8'h03, 8'h03, 3'h0);
    run(`SXA_OP_FILE_EXCLUSIVE_OR, 0, 7'h00, 1, 8'h03, 8'h00, 3'h4);
    chk_file(7'h00, 8'h00);
  endtask
  task swap_ops;
    run(`SXA_OP_NIBBLE_EXCHANGE, 0, 7'h7f, 1, 8'h03, 8'hd3, 3'h4);
    chk_file(7'h7f, 8'hd3);
    run(`SXA_OP_NIBBLE_EXCHANGE, 0, 7'h7f, 0, 8'h3d, 8'h3d, 3'h4);
  endtask
  // Unknown operation codes are ignored: no retirement, no change
  task bad_ops;
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_sel <= 3'h5;
    literal <= 8'h00;
    @(posedge core_clk);
    op_valid <= 1'b0;
    repeat (3) begin
      #1 check({7'h00, op_done}, 8'h00);
      check({7'h00, op_ready}, 8'h01);
      @(posedge core_clk);
    end
    #1 check(acc, 8'h3d);
    check({5'h00, zero_flag, nibble_carry_flag, carry_flag}, 8'h04);
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    check(acc, `SXA_ACC_RESET);
    resetn <= 1'b1;
    lit_ops();
    file_ops();
    swap_ops();
    bad_ops();
    print_verdict();
  end
endmodule
bind sxa_alu sxa_alu_props u_props (.core_clk, .resetn, .op_valid, .op_sel,
  .literal, .target, .op_ready, .op_done, .acc, .result, .carry_flag,
  .nibble_carry_flag, .zero_flag);
